// ### ambient_pkg.sv
/*
 * Constants for the ambient light parameter and result block: register
 * offsets, field positions, reset values and the sample period.
 * Assumes a 25 MHz system clock and byte-wide register access.
 */
`default_nettype none
package ambient_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_PARAM = 8'h84;
	localparam logic [7:0] ADDR_RES_HI = 8'h85;
	localparam logic [7:0] ADDR_RES_LO = 8'h86;

	// ------------------------------------------------------------
	// Parameter byte layout and reset value
	// ------------------------------------------------------------
	localparam int CONT_BIT = 7;
	localparam int RATE_LSB = 4;
	localparam int OFS_BIT = 3;
	localparam int AVG_LSB = 0;
	localparam int FIELD_W = 3;
	// Continuous off, rate 001, offset compensation on, averaging 101.
	localparam logic [7:0] PARAM_RESET = 8'h1d;

	// ------------------------------------------------------------
	// Timing: the slowest sample rate is one sample per second
	// ------------------------------------------------------------
	localparam longint CLK_PERIOD_NS = 40;
	localparam longint SAMPLE_PERIOD_NS = 1_000_000_000;
	localparam longint SAMPLE_CYCLES = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;

	// Measurement sequencer phases.
	typedef enum logic [1:0] {
		PH_IDLE,
		PH_OFFSET,
		PH_CONV,
		PH_DONE
	} phase_t;

endpackage
`default_nettype wire

// ### ambient_light_param_result.sv
/*
 * Ambient light parameter register, measurement sequencer and 16-bit
 * result registers. Assumes a byte register port driven by the serial
 * bus engine on sys_clk, a command register on sys_clk supplying the
 * self-timed and single-shot controls, and a converter that answers each
 * conv_start pulse with one conv_valid pulse carrying conv_data.
 */
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// RULE_01: Bit 7 enables continuous conversion and resets to zero.
// RULE_02: The host uses continuous mode only with single-shot measurements.
// RULE_03: Bits 6:4 set the rate; code zero is one sample per second.
// RULE_04: Bit 3 enables automatic offset compensation and resets to one.
// RULE_05: With compensation on, an offset is measured first and subtracted.
// RULE_06: Bits 2:0 set two to that power conversions per measurement.
// RULE_07: The stored result is the average of the measurement's conversions.
// RULE_08: The averaging field resets to 101, giving 32 conversions.
// RULE_09: A self-timed run keeps its settings until the mode is cycled.
// RULE_10: The 16-bit result is read at offsets 85h and 86h.
// RULE_11: The high byte sits at 85h, the low at 86h, both read-only.
// RULE_12: Single-shot requests are ignored while self-timed mode is on.
// RULE_13: The host changes the parameter byte only while idle.
// RULE_14: Both result bytes are updated together at measurement end.
module ambient_light_param_result
	import ambient_pkg::*;
#(
	parameter longint PERIOD_CYCLES = SAMPLE_CYCLES,
	parameter int CNT_W = 25
) (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic reset,
	// Register port from the serial bus engine.
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Controls from the command register.
	input wire logic selftimed_en,
	input wire logic ambient_enable,
	input wire logic ambient_single_shot_request,
	// Converter handshake.
	output logic conv_start,
	output logic conv_offset,
	input wire logic conv_valid,
	input wire logic [15:0] conv_data,
	// Status.
	output logic ambient_busy,
	output logic ambient_ready
);

	// The fastest rate halves the period seven times, so it must survive
	// that, and the whole period must fit the rate counter.
	if (PERIOD_CYCLES < 128
		|| PERIOD_CYCLES >= (64'd1 << CNT_W)) begin : g_bad_period
		$error("PERIOD_CYCLES does not fit the rate counter");
	end

	typedef struct packed {
		logic [7:0] param;
		logic [7:0] act;
		logic [CNT_W-1:0] rate_cnt;
		logic st_prev;
		logic [15:0] result;
		logic [22:0] acc;
		logic [7:0] left;
		logic [15:0] ofs;
		phase_t phase;
		logic conv_start;
		logic conv_offset;
		logic [7:0] rdata;
		logic busy;
		logic ready;
	} state_t;

	state_t s_q, s_d;
	logic [CNT_W-1:0] period_full;
	assign period_full = CNT_W'(PERIOD_CYCLES - 1);

	// ------------------------------------------------------------
	// Sequencer start: snapshot settings already in act
	// ------------------------------------------------------------
	function automatic state_t begin_meas(input state_t x);
		state_t y;
		y = x;
		y.acc = '0;
		y.ofs = '0;
		y.left = 8'(1 << x.act[AVG_LSB +: FIELD_W]); // [RULE_06]
		y.busy = 1'b1;
		y.conv_start = 1'b1;
		y.conv_offset = x.act[OFS_BIT]; // [RULE_05]
		y.phase = x.act[OFS_BIT] ? PH_OFFSET : PH_CONV;
		return y;
	endfunction

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb begin
		logic st_rise;
		logic go_timed;
		logic [22:0] avg;
		st_rise = 1'b0;
		go_timed = 1'b0;
		avg = '0;
		s_d = s_q;
		s_d.conv_start = 1'b0;
		s_d.ready = 1'b0;
		st_rise = selftimed_en & ~s_q.st_prev;
		s_d.st_prev = selftimed_en;

		// Writes to the result offsets fall through and are dropped.
		if (reg_wr && reg_addr == ADDR_PARAM) begin
			s_d.param = reg_wdata; // [RULE_01] [RULE_03] [RULE_04]
		end

		// Read data is registered, so it appears one cycle after reg_rd.
		if (reg_rd) begin
			unique case (reg_addr)
				ADDR_PARAM: s_d.rdata = s_q.param;
				ADDR_RES_HI: s_d.rdata = s_q.result[15:8]; // [RULE_10] [RULE_11]
				ADDR_RES_LO: s_d.rdata = s_q.result[7:0]; // [RULE_11]
				default: s_d.rdata = '0;
			endcase
		end

		// Rate timer; settings are only taken over when the mode is
		// switched on, so writes during a run wait for the next cycle.
		if (!selftimed_en) begin
			s_d.rate_cnt = '0;
		end else if (st_rise) begin
			s_d.act = s_q.param; // [RULE_09]
			s_d.rate_cnt = '0;
		end else if (s_q.rate_cnt == '0) begin
			go_timed = ambient_enable;
			s_d.rate_cnt = period_full >> s_q.act[RATE_LSB +: FIELD_W]; // [RULE_03]
		end else begin
			s_d.rate_cnt = s_q.rate_cnt - 1'b1;
		end

		unique case (s_q.phase)
			PH_IDLE: begin
				if (go_timed) begin
					s_d = begin_meas(s_d);
				end else if (ambient_single_shot_request && !selftimed_en) begin
					// Single shots take the current byte; ignored in
					// self-timed mode.
					s_d.act = s_q.param; // [RULE_12]
					s_d = begin_meas(s_d);
				end
			end
			PH_OFFSET: begin
				if (conv_valid) begin
					s_d.ofs = conv_data; // [RULE_05]
					s_d.conv_start = 1'b1;
					s_d.conv_offset = 1'b0;
					s_d.phase = PH_CONV;
				end
			end
			PH_CONV: begin
				if (conv_valid) begin
					s_d.acc = s_q.acc + 23'(conv_data);
					s_d.left = s_q.left - 1'b1;
					if (s_q.left == 8'h01) begin
						s_d.phase = PH_DONE;
					end else begin
						s_d.conv_start = 1'b1;
					end
				end
			end
			PH_DONE: begin
				// Whole 16-bit result is stored in one edge.
				avg = s_q.acc >> s_q.act[AVG_LSB +: FIELD_W]; // [RULE_07]
				if (s_q.act[OFS_BIT] && avg[15:0] > s_q.ofs) begin
					s_d.result = avg[15:0] - s_q.ofs; // [RULE_05] [RULE_14]
				end else if (s_q.act[OFS_BIT]) begin
					s_d.result = '0;
				end else begin
					s_d.result = avg[15:0]; // [RULE_14]
				end
				s_d.ready = 1'b1;
				s_d.busy = 1'b0;
				s_d.phase = PH_IDLE;
				// Continuous mode restarts at once, skipping the rate wait.
				if (s_q.act[CONT_BIT] && !selftimed_en) begin
					s_d = begin_meas(s_d); // [RULE_01]
				end
			end
		endcase
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			s_q <= '0;
			s_q.param <= PARAM_RESET; // [RULE_01] [RULE_04] [RULE_08]
			s_q.act <= PARAM_RESET;
			s_q.phase <= PH_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_rdata = s_q.rdata;
	assign conv_start = s_q.conv_start;
	assign conv_offset = s_q.conv_offset;
	assign ambient_busy = s_q.busy;
	assign ambient_ready = s_q.ready;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	AST_PARAM_WRITE: assert property ( // [RULE_03]
		reg_wr && reg_addr == ADDR_PARAM |=> s_q.param == $past(reg_wdata))
		else $error("Parameter write not stored.");
	AST_RESULT_RO: assert property ( // [RULE_11]
		reg_wr && (reg_addr == ADDR_RES_HI || reg_addr == ADDR_RES_LO)
		&& s_q.phase != PH_DONE |=> $stable(s_q.result))
		else $error("Result changed by a write.");
	AST_READ_HIGH: assert property ( // [RULE_10]
		reg_rd && reg_addr == ADDR_RES_HI
		|=> reg_rdata == $past(s_q.result[15:8]))
		else $error("High result byte read wrong.");
	AST_READ_LOW: assert property ( // [RULE_11]
		reg_rd && reg_addr == ADDR_RES_LO
		|=> reg_rdata == $past(s_q.result[7:0]))
		else $error("Low result byte read wrong.");
	AST_SINGLE_IGNORED: assert property ( // [RULE_12]
		s_q.phase == PH_IDLE && selftimed_en && s_q.st_prev
		&& s_q.rate_cnt != '0 && ambient_single_shot_request
		|=> !conv_start && s_q.phase == PH_IDLE)
		else $error("Single shot taken in self-timed mode.");
	AST_CONV_COUNT: assert property ( // [RULE_06]
		$rose(ambient_busy)
		|-> s_q.left == 8'(1 << s_q.act[AVG_LSB +: FIELD_W]))
		else $error("Wrong conversion count.");
	AST_OFFSET_FIRST: assert property ( // [RULE_05]
		$rose(ambient_busy) && s_q.act[OFS_BIT] |-> conv_offset && conv_start)
		else $error("Offset not measured first.");
	AST_HOLD_SETTINGS: assert property ( // [RULE_09]
		selftimed_en && s_q.st_prev |=> $stable(s_q.act))
		else $error("Settings changed during self-timed run.");
	AST_AVERAGE: assert property ( // [RULE_07]
		s_q.phase == PH_DONE && !s_q.act[OFS_BIT]
		|=> s_q.result == $past(16'(s_q.acc >> s_q.act[AVG_LSB +: FIELD_W])))
		else $error("Result is not the average.");
	AST_READY_ATOMIC: assert property ( // [RULE_14]
		!$stable(s_q.result) |-> ambient_ready && $past(s_q.phase) == PH_DONE)
		else $error("Result updated outside completion.");
	AST_CONTINUOUS: assert property ( // [RULE_01]
		s_q.phase == PH_DONE && s_q.act[CONT_BIT] && !selftimed_en
		|=> conv_start && ambient_busy)
		else $error("Continuous mode did not restart.");

	COV_SINGLE: cover property (
		ambient_single_shot_request && !selftimed_en ##[1:300] ambient_ready);
	COV_TIMED: cover property ($rose(selftimed_en) ##[1:300] ambient_ready);
	COV_CONT: cover property (ambient_ready && s_q.act[CONT_BIT]);

endmodule
`default_nettype wire

// ### converter_model.sv
/*
 * Behavioural converter facing the ambient block.
 * Assumes conv_start pulses on sys_clk; answers slow and fast in turn.
 */
`timescale 1ns/100ps
`default_nettype none
module converter_model (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic reset,
	// Requests from the sequencer.
	input wire logic conv_start,
	input wire logic conv_offset,
	// Values to return.
	input wire logic [15:0] base,
	input wire logic [15:0] ofs,
	// Answers.
	output logic conv_valid,
	output logic [15:0] conv_data
);
	logic pend, is_ofs, slow, par;
	logic [1:0] wait_c;
	// Samples alternate base and base+2, so any even count averages base+1.
	// Data toggles outside valid so a stale value is never mistaken.
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			{pend, is_ofs, slow, par, conv_valid} <= '0;
			wait_c <= 2'd0;
			conv_data <= 16'h0000;
		end else begin
			conv_valid <= 1'b0;
			conv_data <= ~conv_data;
			if (conv_start) begin
				pend <= 1'b1;
				is_ofs <= conv_offset;
				wait_c <= slow ? 2'd3 : 2'd1;
				slow <= ~slow;
			end else if (pend && wait_c == 2'd1) begin
				conv_valid <= 1'b1;
				conv_data <= is_ofs ? ofs : base + (par ? 16'd2 : 16'd0);
				par <= is_ofs ? par : ~par;
				pend <= 1'b0;
			end else if (pend) begin
				wait_c <= wait_c - 2'd1;
			end
		end
	end
endmodule
`default_nettype wire

// ### testbench.sv
/*
 * Self-checking bench for the ambient parameter and result block: reset
 * values, register access, single shots, continuous mode and self-timed
 * runs, with random settings and data and a few fixed corner cases.
 * Assumes the converter model in its own file and a 25 MHz sys_clk; the
 * rate period is shortened so that self-timed runs stay short.
 */
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import ambient_pkg::*;

	// ------------------------------------------------------------
	// Signals and instances
	// ------------------------------------------------------------
	localparam longint TB_PERIOD = 1000;
	localparam int CLK_NS = 40;
	localparam int LIMIT = 2000;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic selftimed_en = 1'b0;
	logic ambient_enable = 1'b0;
	logic req = 1'b0;
	logic conv_start;
	logic conv_offset;
	logic conv_valid;
	logic busy;
	logic ready;
	logic [15:0] conv_data;
	logic [15:0] base = 16'h0000;
	logic [15:0] ofs = 16'h0000;
	int n_errors = 0;
	int checks_done = 0;
	int n_starts = 0;
	int n_ready = 0;

	ambient_light_param_result #(
		.PERIOD_CYCLES(TB_PERIOD)
	) ambient_light_param_result_inst (
		.sys_clk(sys_clk),
		.reset(reset),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata),
		.selftimed_en(selftimed_en),
		.ambient_enable(ambient_enable),
		.ambient_single_shot_request(req),
		.conv_start(conv_start),
		.conv_offset(conv_offset),
		.conv_valid(conv_valid),
		.conv_data(conv_data),
		.ambient_busy(busy),
		.ambient_ready(ready)
	);

	converter_model converter_model_inst (
		.sys_clk(sys_clk),
		.reset(reset),
		.conv_start(conv_start),
		.conv_offset(conv_offset),
		.base(base),
		.ofs(ofs),
		.conv_valid(conv_valid),
		.conv_data(conv_data)
	);

	// The clock flips every half period.
	always #(CLK_NS / 2) sys_clk = ~sys_clk;

	// Pulses are counted on the falling edge, where they have settled.
	always @(negedge sys_clk) begin
		if (conv_start === 1'b1) begin
			n_starts++;
		end
		if (ready === 1'b1) begin
			n_ready++;
		end
	end

	// ------------------------------------------------------------
	// Report and compare
	// ------------------------------------------------------------
	task automatic end_sim();
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s exp %h got %h", what, exp, got);
		end
	endtask

	// ------------------------------------------------------------
	// Drivers, all started one step after a rising edge
	// ------------------------------------------------------------
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		step(1);
		reg_wr = 1'b0;
	endtask

	// Read data is registered and holds, so it is taken one edge later.
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		reg_rd = 1'b1;
		reg_addr = a;
		step(1);
		reg_rd = 1'b0;
		step(1);
		d = reg_rdata;
	endtask

	task automatic read_result(output logic [15:0] r);
		logic [7:0] h;
		logic [7:0] l;
		rd(ADDR_RES_HI, h);
		rd(ADDR_RES_LO, l);
		r = {h, l};
	endtask

	task automatic pulse_req();
		req = 1'b1;
		step(1);
		req = 1'b0;
	endtask

	// Waits, bounded, for the next ready pulse; a timeout is a mismatch.
	task automatic wait_ready(output int cyc);
		cyc = 0;
		do begin
			step(1);
			cyc++;
		end while (ready !== 1'b1 && cyc < LIMIT);
		check("ready seen", 16'h0001, 16'(ready === 1'b1));
	endtask

	// The model alternates base and base+2, so any even count averages
	// to base+1; the offset is removed and floored at zero.
	function automatic logic [15:0] exp_res(input logic [15:0] b,
		input logic [15:0] o, input logic on);
		return !on ? b + 16'd1 : (b + 16'd1 > o ? b + 16'd1 - o : 16'h0000);
	endfunction

	// One offset conversion when enabled, then two to the power avg.
	function automatic logic [15:0] exp_starts(input logic [2:0] avg,
		input logic on);
		return 16'((1 << avg) + int'(on));
	endfunction

	// The run needs about 1600 cycles; 20000 can only be a hang.
	initial begin
		#(CLK_NS * 20000);
		n_errors++;
		end_sim();
	end

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		logic [7:0] d;
		logic [7:0] pr;
		logic [15:0] r;
		logic on;
		int s0;
		int r0;
		int cyc;
		int gap;
		time t0;
		void'($urandom(32'h6998));
		repeat (3) @(posedge sys_clk);
		#1;
		reset = 1'b0;
		rd(ADDR_PARAM, d);
		check("param rst", 16'(PARAM_RESET), 16'(d));
		rd(ADDR_RES_HI, d);
		check("res hi rst", 16'h0000, 16'(d));
		rd(ADDR_RES_LO, d);
		check("res lo rst", 16'h0000, 16'(d));
		// Single shots over averaging codes 1..7; the last one floors.
		for (int n = 1; n < 8; n++) begin
			on = (n == 7) ? 1'b1 : 1'($urandom);
			base = 16'($urandom % 60000);
			ofs = (n == 7) ? 16'hffff : 16'($urandom % 512);
			d = {1'b0, 3'(n), on, 3'(n)};
			// Written only while idle, with no request pending.
			wr(ADDR_PARAM, d);
			rd(ADDR_PARAM, pr);
			check("param rw", 16'(d), 16'(pr));
			s0 = n_starts;
			pulse_req();
			wait_ready(cyc);
			read_result(r);
			check("result", exp_res(base, ofs, on), r);
			check("conv count", exp_starts(3'(n), on), 16'(n_starts - s0));
		end
		// The last shot stored zero, so a landed write would show.
		wr(ADDR_RES_HI, 8'h5a);
		rd(ADDR_RES_HI, d);
		check("ro write hi", 16'(r[15:8]), 16'(d));
		wr(ADDR_RES_LO, 8'ha5);
		rd(ADDR_RES_LO, d);
		check("ro write lo", 16'(r[7:0]), 16'(d));
		// Continuous mode is only started by a single shot.
		base = 16'($urandom % 60000);
		wr(ADDR_PARAM, {1'b1, 3'd0, 1'b0, 3'd1});
		pulse_req();
		wait_ready(cyc);
		r0 = n_ready;
		step(100);
		check("cont restart", 16'h0001, 16'(n_ready - r0 > 1));
		check("cont busy", 16'h0001, 16'(busy));
		read_result(r);
		check("cont result", exp_res(base, ofs, 1'b0), r);
		// Self-timed mode with the channel off ends the loop.
		selftimed_en = 1'b1;
		for (int i = 0; i < 100 && busy !== 1'b0; i++) begin
			step(1);
		end
		check("cont stop", 16'h0000, 16'(busy));
		step(2);
		s0 = n_starts;
		pulse_req();
		step(20);
		check("shot while timed", 16'h0000, 16'(n_starts - s0));
		// Self-timed runs at rate code 2 with the channel on.
		selftimed_en = 1'b0;
		wr(ADDR_PARAM, {1'b0, 3'd2, 1'b0, 3'd1});
		base = 16'($urandom % 60000);
		ofs = 16'($urandom % 512);
		ambient_enable = 1'b1;
		selftimed_en = 1'b1;
		wait_ready(cyc);
		t0 = $time;
		s0 = n_starts;
		read_result(r);
		check("timed result", exp_res(base, ofs, 1'b0), r);
		pulse_req();
		// A write during the run must wait until the mode is cycled.
		wr(ADDR_PARAM, {1'b0, 3'd2, 1'b1, 3'd3});
		wait_ready(cyc);
		gap = int'(($time - t0) / CLK_NS);
		check("timed period", 16'(TB_PERIOD >> 2), 16'(gap));
		check("held settings", 16'h0002, 16'(n_starts - s0));
		selftimed_en = 1'b0;
		step(1);
		selftimed_en = 1'b1;
		s0 = n_starts;
		wait_ready(cyc);
		read_result(r);
		check("cycled result", exp_res(base, ofs, 1'b1), r);
		check("cycled count", exp_starts(3'd3, 1'b1), 16'(n_starts - s0));
		end_sim();
	end
endmodule
`default_nettype wire
